/* File: common/fbt_defines.svh */
// Shared constants for the FSK baseband transmit and clock recovery block.
`ifndef FBT_DEFINES_SVH
`define FBT_DEFINES_SVH

// ----------------------------------------------------------------------------
// Transmit register
// ----------------------------------------------------------------------------
`define FBT_BYTE_W          8
`define FBT_TX_PRESET       8'hAA
`define FBT_FIFO_DEPTH      8

// ----------------------------------------------------------------------------
// Clock and data rate
// ----------------------------------------------------------------------------
`define FBT_CLK_HZ          100000000
`define FBT_RATE_MIN_BPS    337
`define FBT_RATE_MAX_BPS    256000
`define FBT_OVERSAMPLE      29
`define FBT_RATE_DIV_W      20
`define FBT_RATE_DIV_RST    20'h003E8

// ----------------------------------------------------------------------------
// Clock recovery lock lengths in preamble bits
// ----------------------------------------------------------------------------
`define FBT_FAST_LOCK_BITS  5'h07
`define FBT_SLOW_LOCK_BITS  5'h0E

// ----------------------------------------------------------------------------
// Bandwidth field (67 kHz to 400 kHz) width
// ----------------------------------------------------------------------------
`define FBT_BW_W            3

`endif

/* File: common/fbt_if.sv */
// Link between the transceiver baseband and its host controller.
`timescale 1ns/10ps
interface fbt_if;
	logic       tx_enable;
	logic [7:0] load_byte;
	logic       load_strobe;
	logic       data_out_high;
	logic       host_interrupt_request_n;
	logic       tx_bit;

	modport device (
		input  tx_enable,
		input  load_byte,
		input  load_strobe,
		output data_out_high,
		output host_interrupt_request_n,
		output tx_bit
	);

	modport host (
		output tx_enable,
		output load_byte,
		output load_strobe,
		input  data_out_high,
		input  host_interrupt_request_n,
		input  tx_bit
	);
endinterface

/* File: common/fbt_pkg.sv */
// Types for the FSK baseband transmit and clock recovery block.
package fbt_pkg;

	typedef enum logic [1:0] {
		FBT_CR_FAST = 2'h0,
		FBT_CR_SLOW = 2'h1,
		FBT_CR_AUTO = 2'h2
	} fbt_cr_mode_e;

	typedef enum logic [1:0] {
		FBT_GAIN_0DB   = 2'h0,
		FBT_GAIN_M6DB  = 2'h1,
		FBT_GAIN_M14DB = 2'h2,
		FBT_GAIN_M20DB = 2'h3
	} fbt_gain_e;

	typedef enum logic [2:0] {
		FBT_ST_IDLE = 3'h1,
		FBT_ST_LOAD = 3'h2,
		FBT_ST_WAIT = 3'h4
	} fbt_host_st_e;

endpackage

/* File: core/fbt_device.sv */
// Transceiver baseband end: transmit shift register, data rate and clock recovery.
//
// Overview of operation
// - Transmit buffer is two chained byte stages.
// - Reset presets both stages to AAh.
// - Re-enabling transmitter keeps register content.
// - Enable starts shifting immediately, no trigger.
// - Unwritten register sends the AAh preset.
// - Room shown by data-out high and interrupt.
// - Host waits for interrupt before disabling.
// - Host ends with an all-zero dummy byte.
// - Analog or digital baseband filter selectable.
// - Digital filter samples at 29x rate, recovered clock.
// - Clock recovery modes fast, slow, automatic.
// - Slow mode locks after twelve to sixteen bits.
// - Fast mode locks after six to eight bits.
// - Automatic starts fast, switches slow after lock.
// - Recovery and rate clock unused with analog.
// - Packets start with alternating preamble.
// - Receive rate programmable, optional prescaler.
// - Receive bandwidth setting 67 to 400 kHz.
// - Input amplifier gain four-way selection.
`timescale 1ns/10ps
`include "fbt_defines.svh"
module fbt_device
	import fbt_pkg::*;
(
	input  wire logic                        clk,
	input  wire logic                        reset,
	fbt_if.device                            link,
	input  wire logic                        digital_filter_sel,
	input  wire logic [`FBT_RATE_DIV_W-1:0]  rate_divider,
	input  wire logic                        prescaler_enable,
	input  wire logic [`FBT_BW_W-1:0]        bandwidth_sel,
	input  wire logic [1:0]                  input_amplifier_gain,
	input  wire logic [1:0]                  clock_recovery_mode,
	input  wire logic                        rx_data_pin,
	output logic                             recovered_clock,
	output logic                             recovered_data,
	output logic                             clock_recovery_locked,
	output logic [`FBT_BW_W-1:0]             bandwidth_out,
	output logic [1:0]                       input_amplifier_out
);

	// ------------------------------------------------------------------------
	// Transmit path
	// ------------------------------------------------------------------------
	logic [7:0]                  stage_hi_ff;
	logic [7:0]                  stage_lo_ff;
	logic                        hi_full_ff;
	logic [2:0]                  bit_cnt_ff;
	logic [`FBT_RATE_DIV_W-1:0]  tx_div_ff;
	logic                        tx_bit_ff;
	logic                        room_ff;
	logic                        tick;
	logic [`FBT_RATE_DIV_W-1:0]  eff_div;

	// Prescaler off multiplies the divider by 8 for coarser, wider range.
	assign eff_div = prescaler_enable ? rate_divider : {rate_divider[`FBT_RATE_DIV_W-4:0], 3'h0};
	assign tick    = link.tx_enable && (tx_div_ff == '0);

	always_ff @(posedge clk) begin
		if (reset) begin
			tx_div_ff <= '0;
		end else if (!link.tx_enable) begin
			// A cleared divider while off puts the first bit out on the first enabled edge.
			tx_div_ff <= '0;
		end else if (tx_div_ff == '0) begin
			tx_div_ff <= eff_div;
		end else begin
			tx_div_ff <= tx_div_ff - 1'b1;
		end
	end

	// Stage lo shifts onto the line; stage hi refills it every eighth bit.
	always_ff @(posedge clk) begin
		if (reset) begin
			stage_hi_ff <= `FBT_TX_PRESET;
			stage_lo_ff <= `FBT_TX_PRESET;
			hi_full_ff  <= 1'b1;
			bit_cnt_ff  <= '0;
			tx_bit_ff   <= 1'b0;
		end else begin
			if (tick) begin
				tx_bit_ff <= stage_lo_ff[7];
				if (bit_cnt_ff == 3'h7) begin
					stage_lo_ff <= stage_hi_ff;
					hi_full_ff  <= 1'b0;
				end else begin
					stage_lo_ff <= {stage_lo_ff[6:0], stage_hi_ff[7]};
				end
				bit_cnt_ff <= bit_cnt_ff + 1'b1;
			end
			// Disabling keeps content; no preset reload.
			if (link.load_strobe && !hi_full_ff) begin
				stage_hi_ff <= link.load_byte;
				hi_full_ff  <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			room_ff <= 1'b0;
		end else begin
			room_ff <= link.tx_enable && !hi_full_ff;
		end
	end

	assign link.tx_bit                   = tx_bit_ff;
	assign link.data_out_high            = room_ff;
	assign link.host_interrupt_request_n = !room_ff;

	// ------------------------------------------------------------------------
	// Receive configuration
	// ------------------------------------------------------------------------
	logic [`FBT_BW_W-1:0] bw_ff;
	logic [1:0]           gain_ff;

	always_ff @(posedge clk) begin
		if (reset) begin
			bw_ff   <= '0;
			gain_ff <= FBT_GAIN_0DB;
		end else begin
			bw_ff   <= bandwidth_sel;
			gain_ff <= input_amplifier_gain;
		end
	end

	assign bandwidth_out       = bw_ff;
	assign input_amplifier_out = gain_ff;

	// ------------------------------------------------------------------------
	// Clock recovery on the 29x sample clock
	// ------------------------------------------------------------------------
	logic [2:0]                 rx_sync_ff;
	logic                       rx_level_ff;
	logic [`FBT_RATE_DIV_W-1:0] smp_div_ff;
	logic                       smp_tick;
	logic [4:0]                 phase_ff;
	logic [4:0]                 edge_cnt_ff;
	logic                       locked_ff;
	logic                       slow_ff;
	logic                       rclk_ff;
	logic                       rdata_ff;
	logic                       cr_run;
	logic [4:0]                 lock_need;

	assign cr_run    = digital_filter_sel;
	assign smp_tick  = cr_run && (smp_div_ff == '0);
	assign lock_need = slow_ff ? `FBT_SLOW_LOCK_BITS : `FBT_FAST_LOCK_BITS;

	always_ff @(posedge clk) begin
		if (reset) begin
			rx_sync_ff  <= '0;
			rx_level_ff <= 1'b0;
		end else begin
			rx_sync_ff <= {rx_sync_ff[1:0], rx_data_pin};
			if (rx_sync_ff[1] == rx_sync_ff[2]) begin
				rx_level_ff <= rx_sync_ff[2];
			end
		end
	end

	// Sample divider runs only with the digital filter; it reloads with eff_div / 29, giving 29 samples per bit when eff_div + 1 is a multiple of 29.
	always_ff @(posedge clk) begin
		if (reset || !cr_run || smp_div_ff == '0) begin
			smp_div_ff <= reset ? '0 : (eff_div / `FBT_RATE_DIV_W'(`FBT_OVERSAMPLE));
		end else begin
			smp_div_ff <= smp_div_ff - 1'b1;
		end
	end

	logic rx_prev_ff;

	always_ff @(posedge clk) begin
		if (reset || !cr_run) begin
			phase_ff    <= '0;
			edge_cnt_ff <= '0;
			locked_ff   <= 1'b0;
			slow_ff     <= 1'b0;
			rclk_ff     <= 1'b0;
			rdata_ff    <= 1'b0;
			rx_prev_ff  <= 1'b0;
		end else if (smp_tick) begin
			rx_prev_ff <= rx_level_ff;
			if (rx_level_ff != rx_prev_ff) begin
				phase_ff <= '0; // Align on each preamble edge.
				if (!locked_ff && edge_cnt_ff != 5'h1F) begin
					edge_cnt_ff <= edge_cnt_ff + 1'b1;
				end
			end else begin
				phase_ff <= (phase_ff == 5'(`FBT_OVERSAMPLE - 1)) ? '0 : phase_ff + 1'b1;
			end
			if (!locked_ff && edge_cnt_ff >= lock_need) begin
				locked_ff <= 1'b1;
			end
			// Slow or automatic-after-lock uses the slow tracking set.
			slow_ff <= (clock_recovery_mode == FBT_CR_SLOW) ||
				((clock_recovery_mode == FBT_CR_AUTO) && locked_ff);
			rclk_ff <= locked_ff && (phase_ff < 5'(`FBT_OVERSAMPLE / 2));
			if (phase_ff == 5'(`FBT_OVERSAMPLE / 2)) begin
				rdata_ff <= rx_level_ff;
			end
		end
	end

	assign recovered_clock       = rclk_ff;
	assign recovered_data        = rdata_ff;
	assign clock_recovery_locked = locked_ff;

endmodule // fbt_device

/* File: core/fbt_fifo.sv */
// Parameterised valid/ready FIFO.
`timescale 1ns/10ps
module fbt_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             reset,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0]    wr_ff;
	logic [AW-1:0]    rd_ff;
	logic [AW:0]      cnt_ff;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_ff != DEPTH[AW:0]);
	assign out_valid = (cnt_ff != '0);
	assign out_data  = mem_ff[rd_ff];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			wr_ff  <= '0;
			rd_ff  <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // fbt_fifo

/* File: core/fbt_host.sv */
// Host controller end: buffers bytes and feeds the transmit register when room is shown.
`timescale 1ns/10ps
`include "fbt_defines.svh"
module fbt_host
	import fbt_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       reset,
	fbt_if.host             link,
	input  wire logic [7:0] user_data,
	input  wire logic       user_valid,
	output logic            user_ready,
	input  wire logic       user_last,
	input  wire logic       user_start,
	output logic            busy
);
	fbt_host_st_e st_ff;
	logic [7:0]   f_data;
	logic         f_valid;
	logic         f_ready;
	logic         en_ff;
	logic         strobe_ff;
	logic [7:0]   byte_ff;
	logic         last_pend_ff;
	logic         dummy_sent_ff;
	logic [1:0]   irq_sync_ff;
	logic         hold_ff;
	logic         take;

	fbt_fifo #(.WIDTH(`FBT_BYTE_W), .DEPTH(`FBT_FIFO_DEPTH)) i_fbt_fifo (
		.clk       (clk),
		.reset     (reset),
		.in_data   (user_data),
		.in_valid  (user_valid),
		.in_ready  (user_ready),
		.out_data  (f_data),
		.out_valid (f_valid),
		.out_ready (f_ready)
	);

	assign take    = !link.host_interrupt_request_n && irq_sync_ff[1] && !strobe_ff && !hold_ff;
	assign f_ready = (st_ff == FBT_ST_LOAD) && take && !last_pend_ff;

	// Blocks a second load while the room shown is still the one just used.
	always_ff @(posedge clk) begin
		if (reset) begin
			hold_ff <= 1'b0;
		end else if (strobe_ff) begin
			hold_ff <= 1'b1;
		end else if (link.host_interrupt_request_n) begin
			hold_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			irq_sync_ff <= '0;
		end else begin
			irq_sync_ff <= {irq_sync_ff[0], !link.host_interrupt_request_n};
		end
	end

	// Loads only after room is shown; ends with a zero dummy and waits for the next interrupt.
	always_ff @(posedge clk) begin
		if (reset) begin
			st_ff         <= FBT_ST_IDLE;
			en_ff         <= 1'b0;
			strobe_ff     <= 1'b0;
			byte_ff       <= '0;
			last_pend_ff  <= 1'b0;
			dummy_sent_ff <= 1'b0;
		end else begin
			strobe_ff <= 1'b0;
			case (st_ff)
				FBT_ST_IDLE: begin
					if (user_start) begin
						en_ff         <= 1'b1;
						last_pend_ff  <= 1'b0;
						dummy_sent_ff <= 1'b0;
						st_ff         <= FBT_ST_LOAD;
					end
				end
				FBT_ST_LOAD: begin
					if (take) begin
						if (last_pend_ff) begin
							byte_ff       <= 8'h00;
							strobe_ff     <= 1'b1;
							dummy_sent_ff <= 1'b1;
							st_ff         <= FBT_ST_WAIT;
						end else if (f_valid) begin
							byte_ff      <= f_data;
							strobe_ff    <= 1'b1;
							last_pend_ff <= user_last;
						end
					end
				end
				FBT_ST_WAIT: begin
					if (take) begin
						en_ff <= 1'b0;
						st_ff <= FBT_ST_IDLE;
					end
				end
				default: st_ff <= FBT_ST_IDLE;
			endcase
		end
	end

	assign link.tx_enable   = en_ff;
	assign link.load_byte   = byte_ff;
	assign link.load_strobe = strobe_ff;
	assign busy             = (st_ff != FBT_ST_IDLE);
endmodule // fbt_host

/* File: dv/fbt_assertions.sv */
// Concurrent checks on the link between the baseband and its host.
`timescale 1ns/10ps
module fbt_checker (
	input logic       clk,
	input logic       reset,
	input logic       tx_enable,
	input logic [7:0] load_byte,
	input logic       load_strobe,
	input logic       data_out_high,
	input logic       host_interrupt_request_n,
	input logic       tx_bit
);
	// ------------------------------------------------------------------------
	// Link checks
	// ------------------------------------------------------------------------
	localparam int ROOM_MAX = 100;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	sequence s_take;
		data_out_high && load_strobe && tx_enable;
	endsequence

	sequence s_drop;
		$fell(data_out_high) && tx_enable;
	endsequence

	a_irq_mirrors_room: assert property (host_interrupt_request_n != data_out_high)
		else $error("interrupt line does not mirror the room flag");
	a_room_drops: assert property (s_take |-> ##2 !data_out_high)
		else $error("room flag stayed high after a byte was taken");
	a_room_stands: assert property (data_out_high && !load_strobe && !$past(load_strobe) && tx_enable |=> data_out_high)
		else $error("room flag fell without a byte taken");
	a_room_returns: assert property (s_drop |-> ##[1:ROOM_MAX] (data_out_high || !tx_enable))
		else $error("room flag did not return after a byte period");
	a_room_gap: assert property (s_drop |=> !data_out_high [*8])
		else $error("room flag returned too early");
	a_strobe_on_room: assert property (load_strobe |-> data_out_high)
		else $error("byte loaded without room shown");
	a_strobe_pulse: assert property (load_strobe |=> !load_strobe)
		else $error("load strobe longer than one cycle");
	a_disable_after_irq: assert property ($fell(tx_enable) |-> $past(data_out_high))
		else $error("transmitter disabled before the interrupt");
	a_bit_hold: assert property ($changed(tx_bit) && tx_enable |=> ($stable(tx_bit) || !tx_enable) [*3])
		else $error("transmit bit changed within a bit period");
	a_no_room_idle: assert property (!tx_enable [*3] |-> !data_out_high)
		else $error("room shown while transmitter is off");
endmodule // fbt_checker

/* File: dv/fsk_baseband_tx_and_clock_recovery_test.sv */
// Bench for the baseband transmit path, its host end and the clock recovery.
`timescale 1ns/10ps
`include "fbt_defines.svh"
module fsk_baseband_tx_and_clock_recovery_test
	import fbt_pkg::*;
;
	// ------------------------------------------------------------------------
	// Signals and instances
	// ------------------------------------------------------------------------
	logic                       clk;
	logic                       reset;
	logic                       dig_sel;
	logic [`FBT_RATE_DIV_W-1:0] rate_div;
	logic                       presc_en;
	logic [`FBT_BW_W-1:0]       bw_sel;
	logic [1:0]                 gain;
	logic [1:0]                 cr_mode;
	logic                       rx_pin;
	logic                       locked;
	logic                       rclk;
	logic                       rdata;
	logic [`FBT_BW_W-1:0]       bw_out;
	logic [1:0]                 gain_out;
	logic [7:0]                 u_data;
	logic                       u_valid;
	logic                       u_ready;
	logic                       u_last;
	logic                       u_start;
	logic                       busy;
	int                         err_total = 0;
	int                         num_checks = 0;
	int                         cycles = 0;

	fbt_if lnk();

	fbt_device i_fbt_device (.clk(clk), .reset(reset), .link(lnk), .digital_filter_sel(dig_sel),
		.rate_divider(rate_div), .prescaler_enable(presc_en), .bandwidth_sel(bw_sel),
		.input_amplifier_gain(gain), .clock_recovery_mode(cr_mode), .rx_data_pin(rx_pin),
		.recovered_clock(rclk), .recovered_data(rdata), .clock_recovery_locked(locked),
		.bandwidth_out(bw_out), .input_amplifier_out(gain_out));

	fbt_host i_fbt_host (.clk(clk), .reset(reset), .link(lnk), .user_data(u_data), .user_valid(u_valid),
		.user_ready(u_ready), .user_last(u_last), .user_start(u_start), .busy(busy));

	fbt_checker i_fbt_checker (.clk(clk), .reset(reset), .tx_enable(lnk.tx_enable), .load_byte(lnk.load_byte),
		.load_strobe(lnk.load_strobe), .data_out_high(lnk.data_out_high),
		.host_interrupt_request_n(lnk.host_interrupt_request_n), .tx_bit(lnk.tx_bit));

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	// A hang ends the run as a failure.
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			err_total++;
			complete_run();
		end
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic do_reset();
		reset = 1;
		repeat (12) @(negedge clk);
		reset = 0;
	endtask

	// Leaves valid high so back-to-back pushes never toggle it in one step.
	task automatic push(logic [7:0] b);
		u_data = b;
		u_valid = 1;
		while (!u_ready) @(negedge clk);
		@(negedge clk);
	endtask

	// Starts the host and samples the line once per bit, per cycles apart, first three cycles after enable.
	task automatic capture(int n, int per, int nbits, output logic [127:0] got);
		int loads;
		got = '0;
		loads = 0;
		u_last = (n == 1);
		u_start = 1;
		@(negedge clk);
		u_start = 0;
		while (!lnk.tx_enable) @(negedge clk);
		repeat (3) @(negedge clk);
		for (int i = 0; i < nbits; i++) begin
			got = {got[126:0], lnk.tx_bit};
			repeat (per) begin
				@(negedge clk);
				if (lnk.load_strobe)
					loads++;
				if (loads >= n - 1)
					u_last = 1;
			end
		end
		while (busy) @(negedge clk);
		u_last = 0;
	endtask

	task automatic t_fill_send();
		logic [127:0] got;
		logic [127:0] exp;
		exp = {`FBT_TX_PRESET, `FBT_TX_PRESET};
		for (int i = 0; i < `FBT_FIFO_DEPTH; i++) begin
			push(8'h13 + 8'h25 * i[7:0]);
			exp = {exp[119:0], u_data};
		end
		check("fifo full", u_ready, 16'h0000);
		u_valid = 0;
		capture(`FBT_FIFO_DEPTH, 9, 80, got);
		for (int i = 0; i < 5; i++)
			check("tx stream", got[79 - 16 * i -: 16], exp[79 - 16 * i -: 16]);
		check("fifo drained", u_ready, 16'h0001);
		check("tx off", lnk.tx_enable, 16'h0000);
		$display("fill and send done");
	endtask

	task automatic t_reenable();
		logic [127:0] got;
		presc_en = 0;
		rate_div = 1;
		push(8'hC3);
		u_valid = 0;
		capture(1, 9, 16, got);
		check("no preset reload", got[15:0], {8'h00, 8'hC3});
		$display("re-enable done");
	endtask

	task automatic send_bits(int n);
		repeat (n) begin
			rx_pin = ~rx_pin;
			repeat (87) @(negedge clk);
		end
	endtask

	task automatic t_lock(logic [1:0] mode, logic dig, int early, int late);
		int   rises;
		logic prev;
		rx_pin = 0;
		cr_mode = mode;
		dig_sel = dig;
		rate_div = 86;
		presc_en = 1;
		do_reset();
		send_bits(early);
		check("lock early", locked, 16'h0000);
		send_bits(late - early);
		check("lock late", locked, dig);
		rx_pin = 1;
		repeat (87) @(negedge clk);
		check("recovered data", rdata, dig);
		rises = 0;
		repeat (174) begin
			prev = rclk;
			@(negedge clk);
			if (rclk && !prev)
				rises++;
		end
		check("recovered clock", rises[15:0], dig ? 16'h0002 : 16'h0000);
		$display("lock mode %0d filter %0d done", mode, dig);
	endtask

	task automatic t_settings();
		for (int i = 0; i < 8; i++) begin
			bw_sel = i[2:0];
			gain = i[1:0];
			repeat (2) @(negedge clk);
			check("bandwidth", bw_out, i[2:0]);
			check("gain", gain_out, i[1:0]);
		end
		$display("settings done");
	endtask

	// ------------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------------
	initial begin
		reset = 1;
		dig_sel = 1;
		rate_div = 8;
		presc_en = 1;
		bw_sel = '0;
		gain = '0;
		cr_mode = FBT_CR_FAST;
		rx_pin = 0;
		u_data = '0;
		u_valid = 0;
		u_last = 0;
		u_start = 0;
		repeat (12) @(negedge clk);
		reset = 0;
		t_fill_send();
		t_reenable();
		t_settings();
		t_lock(FBT_CR_FAST, 1, 4, 10);
		t_lock(FBT_CR_SLOW, 1, 10, 18);
		t_lock(FBT_CR_AUTO, 1, 4, 10);
		t_lock(FBT_CR_FAST, 0, 4, 18);
		complete_run();
	end
endmodule // fsk_baseband_tx_and_clock_recovery_test
